// >>> logic/signal_measure_timer.sv
/*
  Signal measurement timer control, status and counting logic with an APB
  register slave. Assumes clock, window and signal sources arrive
  asynchronously from other peripherals and are slow against i_ref_clk.
*/
// Behaviour
// [RULE1] Enable clear keeps all state in reset and drops the clock request; pcap_reg and wcap_reg keep their last values instead.
// [RULE2] With halt set, a period match holds the count at the period.
// [RULE3] With halt clear, a period match returns the count to zero.
// [RULE4] Window polarity one makes the window active low, falling edge.
// [RULE5] Signal polarity one makes the signal active low, falling edge.
// [RULE6] Clock polarity chooses the falling or rising clock edge to count.
// [RULE7] Prescale field divides the timer clock by one, two, four or eight.
// [RULE8] Go bit permits counting and acquisition; clear inhibits both.
// [RULE9] Repeat bit chooses continuous or single acquisition.
// [RULE10] Mode field chooses one of eleven operations; the rest are reserved.
// [RULE11] Writing one requests a period capture update; hardware clears it.
// [RULE12] Writing one requests a width capture update; hardware clears it.
// [RULE13] Writing one requests a count reset; reads zero when done.
// [RULE14] Status shows whether the count is currently incrementing.
// [RULE15] Status shows whether the window is open.
// [RULE16] Status shows whether an acquisition is in progress.
// [RULE17] Clock select field picks one of eight timer clocks.
// [RULE18] Window select field picks the window source from peripheral outputs.
// [RULE19] Window codes zero to two pick pin, low and medium oscillators.
// [RULE20] A count equal to the period raises the period match pulse.
// [RULE21] A separate signal select field picks the signal source.
// [RULE22] Reserved modes acquire nothing and leave count and captures alone.
// [RULE23] Prescaler follows the polarity stage and restarts while disabled.
`include "smt_params.svh"
`timescale 1ns/1ps
`default_nettype none
module signal_measure_timer #(
  parameter int CW = 24,
  parameter int AW = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [7:0] i_clk_src,
  input wire logic [31:0] i_win_src,
  input wire logic [31:0] i_sig_src,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output logic o_clk_req,
  output logic o_period_match,
  output logic o_period_acq,
  output logic o_width_acq
);
  function automatic logic hit(input logic [AW-1:0] a, input logic [11:0] idx);
    hit = (a == AW'({idx, 2'b00}));
  endfunction : hit

  logic [7:0] ctrl0_reg, ctrl1_reg, stat_req_reg;
  logic [2:0] clksel_reg;
  logic [4:0] sigsel_reg, winsel_reg;
  smt_pkg::count_t count_reg, period_reg, pcap_reg, wcap_reg;
  logic [7:0] clk_s1_reg, clk_s2_reg;
  logic [31:0] win_s1_reg, win_s2_reg, sig_s1_reg, sig_s2_reg;
  logic clk_prev_reg, win_prev_reg, sig_prev_reg;
  logic [2:0] presc_reg;
  logic armed_reg, done_reg;
  logic ready_reg;
  logic [31:0] rdata_reg;
  logic slverr_reg;

  // Register bus decode: no wait state; read data is registered in the setup cycle.
  wire setup = i_psel & ~i_penable;
  wire access = i_psel & i_penable & ready_reg;
  wire wr = access & i_pwrite;
  wire a_count = hit(i_paddr, `SMT_IDX_COUNT);
  wire a_pcap = hit(i_paddr, `SMT_IDX_PCAP);
  wire a_wcap = hit(i_paddr, `SMT_IDX_WCAP);
  wire a_period = hit(i_paddr, `SMT_IDX_PERIOD);
  wire a_c0 = hit(i_paddr, `SMT_IDX_CTRL0);
  wire a_c1 = hit(i_paddr, `SMT_IDX_CTRL1);
  wire a_stat = hit(i_paddr, `SMT_IDX_STAT);
  wire a_clk = hit(i_paddr, `SMT_IDX_CLKSEL);
  wire a_sig = hit(i_paddr, `SMT_IDX_SIGSEL);
  wire a_win = hit(i_paddr, `SMT_IDX_WINSEL);
  wire mapped = a_count | a_pcap | a_wcap | a_period | a_c0 | a_c1 | a_stat
      | a_clk | a_sig | a_win;

  wire en = ctrl0_reg[`SMT_C0_EN];
  wire halt = ctrl0_reg[`SMT_C0_HALT];
  wire [1:0] ps = ctrl0_reg[`SMT_C0_PS_HI:`SMT_C0_PS_LO];
  wire go = ctrl1_reg[`SMT_C1_GO];
  wire repeat_on = ctrl1_reg[`SMT_C1_REPEAT];
  wire [3:0] mode = ctrl1_reg[`SMT_C1_MODE_HI:`SMT_C1_MODE_LO];
  wire mode_ok = (mode <= smt_pkg::MODE_WINDOWED_COUNTER); // RULE10 RULE22
  wire pcap_req = stat_req_reg[`SMT_ST_PCAP_REQ];
  wire wcap_req = stat_req_reg[`SMT_ST_WCAP_REQ];
  wire rst_req = stat_req_reg[`SMT_ST_RST_REQ];

  // Source selection after synchronisation; polarity folds to active high.
  wire clk_lvl = clk_s2_reg[clksel_reg] ^ ctrl0_reg[`SMT_C0_CLOCK_POLARITY]; // RULE6 RULE17
  wire win_lvl = win_s2_reg[winsel_reg] ^ ctrl0_reg[`SMT_C0_WINDOW_POLARITY]; // RULE4 RULE18 RULE19
  wire sig_lvl = sig_s2_reg[sigsel_reg] ^ ctrl0_reg[`SMT_C0_SIGNAL_POLARITY]; // RULE5 RULE21
  wire clk_edge = clk_lvl & ~clk_prev_reg;
  wire win_rise = win_lvl & ~win_prev_reg;
  wire win_fall = ~win_lvl & win_prev_reg;
  wire sig_rise = sig_lvl & ~sig_prev_reg;

  // Prescaler: ticks when its count reaches the mask of the chosen ratio.
  wire [2:0] ps_mask = 3'((4'h1 << ps) - 4'h1); // RULE7
  wire time_tick = clk_edge & ((presc_reg & ps_mask) == ps_mask); // RULE23
  wire [2:0] presc_next = (!en || time_tick) ? `SMT_PS_ONE
      : (clk_edge ? 3'(presc_reg + 3'h1) : presc_reg); // RULE23

  wire is_counter = mode[3];
  wire count_src = is_counter ? sig_rise : time_tick;
  wire m_gtimer = (mode == smt_pkg::MODE_GATED_TIMER);
  wire m_pd = (mode == smt_pkg::MODE_PERIOD_DUTY);
  wire m_hl = (mode == smt_pkg::MODE_HIGH_LOW);
  wire m_win = (mode == smt_pkg::MODE_WINDOWED);
  wire m_gwin = (mode == smt_pkg::MODE_GATED_WINDOWED);
  wire m_tof = (mode == smt_pkg::MODE_TIME_OF_FLIGHT);
  wire m_cap = (mode == smt_pkg::MODE_CAPTURE);
  wire m_cnt = (mode == smt_pkg::MODE_COUNTER);
  wire m_gcnt = (mode == smt_pkg::MODE_GATED_COUNTER);
  wire m_wcnt = (mode == smt_pkg::MODE_WINDOWED_COUNTER);
  wire gate = (m_gtimer | m_gwin | m_gcnt | m_wcnt) ? win_lvl
      : (m_tof ? armed_reg : 1'b1);
  wire run = en & go & mode_ok & ~done_reg; // RULE8 RULE9 RULE22
  wire inc = run & gate & count_src; // RULE8
  wire at_period = (count_reg == period_reg);
  wire match = inc & at_period; // RULE20

  // Mode-dependent capture and reset events, all inhibited unless running.
  wire pcap_ev = run & (((m_pd | m_hl | m_win | m_gwin | m_cap) & win_rise)
      | (m_wcnt & win_rise & armed_reg) | (m_tof & sig_rise & armed_reg));
  wire wcap_ev = run & (((m_pd | m_hl | m_cap | m_cnt | m_gcnt | m_wcnt)
      & win_fall) | (m_tof & win_rise & armed_reg));
  wire hw_clr = run & (((m_pd | m_hl | m_win | m_gwin | m_wcnt | m_tof)
      & win_rise) | (m_hl & win_fall) | (m_tof & sig_rise & armed_reg));
  wire armed_next = !en ? 1'b0 : (run & (m_tof | m_wcnt) & win_rise ? 1'b1
      : (run & m_tof & sig_rise ? 1'b0 : armed_reg));
  wire done_next = en & go & (done_reg | (~repeat_on & (pcap_ev | wcap_ev))); // RULE9

  wire [CW-1:0] count_next = !en ? '0 // RULE1
      : (rst_req | hw_clr) ? '0 // RULE13
      : !inc ? count_reg // RULE8 RULE22
      : at_period ? (halt ? period_reg : '0) // RULE2 RULE3
      : CW'(count_reg + 1'b1);

  // A software write of one wins over the hardware clear in the same cycle.
  wire wr_stat = wr & a_stat;
  wire [7:0] req_set = wr_stat ? (i_pwdata[7:0] & ((8'h1 << `SMT_ST_PCAP_REQ)
      | (8'h1 << `SMT_ST_WCAP_REQ) | (8'h1 << `SMT_ST_RST_REQ))) : 8'h00;
  wire [7:0] req_next = en ? req_set : 8'h00; // RULE11 RULE12 RULE13

  wire [7:0] stat_rd = stat_req_reg | ({7'h00, run & gate} << `SMT_ST_RUN)
      | ({7'h00, win_lvl} << `SMT_ST_WIN)
      | ({7'h00, run & (is_counter | ~(mode == smt_pkg::MODE_TIMER))}
      << `SMT_ST_ACQ); // RULE14 RULE15 RULE16
  wire [31:0] rd_mux = a_count ? 32'(count_reg) : a_pcap ? 32'(pcap_reg)
      : a_wcap ? 32'(wcap_reg) : a_period ? 32'(period_reg)
      : a_c0 ? {24'h0, ctrl0_reg} : a_c1 ? {24'h0, ctrl1_reg}
      : a_stat ? {24'h0, stat_rd} : a_clk ? {29'h0, clksel_reg}
      : a_sig ? {27'h0, sigsel_reg} : a_win ? {27'h0, winsel_reg} : 32'h0;

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      ready_reg <= 1'b0;
      rdata_reg <= 32'h0;
      slverr_reg <= 1'b0;
    end else begin
      ready_reg <= setup;
      rdata_reg <= setup ? rd_mux : rdata_reg;
      slverr_reg <= setup & ~mapped;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      ctrl0_reg <= `SMT_RST_BYTE;
      ctrl1_reg <= `SMT_RST_BYTE;
      clksel_reg <= `SMT_RST_CLOCK_SOURCE_SELECT;
      sigsel_reg <= `SMT_RST_SEL;
      winsel_reg <= `SMT_RST_SEL;
      period_reg <= '0;
    end else begin
      ctrl0_reg <= (wr & a_c0) ? (i_pwdata[7:0] & 8'hBF) : ctrl0_reg;
      ctrl1_reg <= (wr & a_c1) ? (i_pwdata[7:0] & 8'hCF) : ctrl1_reg;
      clksel_reg <= (wr & a_clk) ? i_pwdata[`SMT_CLOCK_SOURCE_SELECT_HI:0] : clksel_reg;
      sigsel_reg <= (wr & a_sig) ? i_pwdata[`SMT_SEL_HI:0] : sigsel_reg;
      winsel_reg <= (wr & a_win) ? i_pwdata[`SMT_SEL_HI:0] : winsel_reg;
      period_reg <= (wr & a_period) ? i_pwdata[CW-1:0] : period_reg;
    end
  end

  // Two-flop synchronisers; only the second stage feeds the selectors.
  always_ff @(posedge i_ref_clk) begin
    clk_s1_reg <= i_clk_src;
    clk_s2_reg <= clk_s1_reg;
    win_s1_reg <= i_win_src;
    win_s2_reg <= win_s1_reg;
    sig_s1_reg <= i_sig_src;
    sig_s2_reg <= sig_s1_reg;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      clk_prev_reg <= 1'b0;
      win_prev_reg <= 1'b0;
      sig_prev_reg <= 1'b0;
      presc_reg <= `SMT_PS_ONE;
      armed_reg <= 1'b0;
      done_reg <= 1'b0;
      stat_req_reg <= `SMT_RST_BYTE;
      count_reg <= '0;
    end else begin
      clk_prev_reg <= en & clk_lvl; // RULE1
      win_prev_reg <= en & win_lvl;
      sig_prev_reg <= en & sig_lvl;
      presc_reg <= presc_next;
      armed_reg <= armed_next;
      done_reg <= done_next;
      stat_req_reg <= req_next;
      // The count stays in reset while disabled, even against a bus write.
      count_reg <= (wr & a_count & en) ? i_pwdata[CW-1:0] : count_next; // RULE1
    end
  end

  // Captures keep their last value while disabled so software can still read.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      pcap_reg <= '0;
      wcap_reg <= '0;
      o_period_match <= 1'b0;
      o_period_acq <= 1'b0;
      o_width_acq <= 1'b0;
      o_clk_req <= 1'b0;
    end else begin
      pcap_reg <= (pcap_req | pcap_ev) ? count_reg : pcap_reg; // RULE11
      wcap_reg <= (wcap_req | wcap_ev) ? count_reg : wcap_reg; // RULE12
      o_period_match <= match; // RULE2 RULE3 RULE20
      o_period_acq <= pcap_ev;
      o_width_acq <= wcap_ev;
      o_clk_req <= en; // RULE1
    end
  end

  assign o_pready = ready_reg;
  assign o_prdata = rdata_reg;
  assign o_pslverr = slverr_reg;

  property p_disabled;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      !en |=> (count_reg == '0) && !o_clk_req && !armed_reg;
  endproperty
  a_disabled: assert property (p_disabled) else $error("state kept while off"); // RULE1

  property p_halt;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      match && halt && !rst_req && !hw_clr && !(wr & a_count)
      |=> (count_reg == $past(period_reg)) && o_period_match;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not hold"); // RULE2

  property p_wrap;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      match && !halt && !rst_req && !hw_clr && !(wr & a_count)
      |=> (count_reg == '0) ##1 !o_period_match;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at period"); // RULE3

  property p_presc;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      time_tick && en && (ps == 2'b11) |-> $past(presc_reg) == 3'h7 - 3'h1
        || presc_reg == 3'h7;
  endproperty
  a_presc: assert property (p_presc) else $error("prescale ratio wrong"); // RULE7

  property p_go;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      en && !go && !rst_req && !(wr & a_count)
      |=> $stable(count_reg) && !o_period_acq && !o_width_acq;
  endproperty
  a_go: assert property (p_go) else $error("count moved without go"); // RULE8

  property p_reserved;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      en && !mode_ok && !rst_req && !pcap_req && !(wr & a_count)
      |=> $stable(count_reg) && $stable(pcap_reg);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved mode acted"); // RULE22

  property p_pcap_req;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      pcap_req && !wr_stat |=> !pcap_req && (pcap_reg == $past(count_reg));
  endproperty
  a_pcap_req: assert property (p_pcap_req) else $error("period update lost"); // RULE11

  property p_wcap_req;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      wcap_req && !wr_stat |=> !wcap_req && (wcap_reg == $past(count_reg));
  endproperty
  a_wcap_req: assert property (p_wcap_req) else $error("width update lost"); // RULE12

  property p_rst_req;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      rst_req && !wr_stat && !(wr & a_count) |=> !rst_req && count_reg == '0;
  endproperty
  a_rst_req: assert property (p_rst_req) else $error("timer reset lost"); // RULE13

  c_match: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_period_match);
  c_pacq: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
    o_period_acq ##[1:200] o_width_acq);
  c_single: cover property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !repeat_on && done_reg);
endmodule : signal_measure_timer
`default_nettype wire

// >>> inc/smt_params.svh
/*
  Offsets, field positions and reset values of the signal measurement timer.
  Assumes it is included once per compile unit by its bare name.
*/
`ifndef SMT_PARAMS_SVH
`define SMT_PARAMS_SVH

`define SMT_IDX_COUNT 12'h48C
`define SMT_IDX_PCAP 12'h48F
`define SMT_IDX_WCAP 12'h492
`define SMT_IDX_PERIOD 12'h495
`define SMT_IDX_CTRL0 12'h498
`define SMT_IDX_CTRL1 12'h499
`define SMT_IDX_STAT 12'h49A
`define SMT_IDX_CLKSEL 12'h49B
`define SMT_IDX_SIGSEL 12'h49C
`define SMT_IDX_WINSEL 12'h49D

`define SMT_C0_EN 7
`define SMT_C0_HALT 5
`define SMT_C0_WINDOW_POLARITY 4
`define SMT_C0_SIGNAL_POLARITY 3
`define SMT_C0_CLOCK_POLARITY 2
`define SMT_C0_PS_HI 1
`define SMT_C0_PS_LO 0
`define SMT_C1_GO 7
`define SMT_C1_REPEAT 6
`define SMT_C1_MODE_HI 3
`define SMT_C1_MODE_LO 0
`define SMT_ST_PCAP_REQ 7
`define SMT_ST_WCAP_REQ 6
`define SMT_ST_RST_REQ 4
`define SMT_ST_RUN 2
`define SMT_ST_WIN 1
`define SMT_ST_ACQ 0
`define SMT_SEL_HI 4
`define SMT_CLOCK_SOURCE_SELECT_HI 2

`define SMT_RST_BYTE 8'h00
`define SMT_RST_SEL 5'h00
`define SMT_RST_CLOCK_SOURCE_SELECT 3'h0
`define SMT_PS_ONE 3'h0

`endif

// >>> inc/smt_pkg.sv
/*
  Types shared by the signal measurement timer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package smt_pkg;
  typedef enum logic [3:0] {
    MODE_TIMER = 4'h0,
    MODE_GATED_TIMER = 4'h1,
    MODE_PERIOD_DUTY = 4'h2,
    MODE_HIGH_LOW = 4'h3,
    MODE_WINDOWED = 4'h4,
    MODE_GATED_WINDOWED = 4'h5,
    MODE_TIME_OF_FLIGHT = 4'h6,
    MODE_CAPTURE = 4'h7,
    MODE_COUNTER = 4'h8,
    MODE_GATED_COUNTER = 4'h9,
    MODE_WINDOWED_COUNTER = 4'hA
  } mode_e;
  typedef logic [23:0] count_t;
endpackage : smt_pkg
`default_nettype wire

// >>> tb/tb.sv
/*
  Self-checking bench for the measurement timer register slave and counter.
  Assumes the design's APB answer with no wait state and 2-flop source sync.
*/
`include "smt_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, nrst, psel, penable, pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata, wsrc, ssrc, rdata, prdata;
  logic [7:0] csrc;
  logic pready, pslverr, clk_req, pm, err;
  int fails = 0;
  int n_checks = 0;
  int pm_cnt = 0;
  int pa_cnt = 0;
  int wa_cnt = 0;
  logic pacq, wacq;
  int m;

  signal_measure_timer signal_measure_timer_i (.i_ref_clk(clk),
    .i_nrst(nrst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_clk_src(csrc), .i_win_src(wsrc),
    .i_sig_src(ssrc), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .o_clk_req(clk_req), .o_period_match(pm),
    .o_period_acq(pacq), .o_width_acq(wacq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) if (pm === 1'b1) pm_cnt++;
  always @(posedge clk) if (pacq === 1'b1) pa_cnt++;
  always @(posedge clk) if (wacq === 1'b1) wa_cnt++;

  task automatic print_verdict;
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // The request is held until pready is sampled high, then released.
  task automatic xfer(input logic wr, input logic [11:0] idx,
                      input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      print_verdict();
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [11:0] idx,
                     input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0000_0000);
    chk(nm, rdata, exp);
  endtask : rdc

  // Sources must hold each level long enough to pass the synchronisers.
  task automatic lvl(input int n, input logic v);
    csrc[n] <= v;
    repeat (8) @(posedge clk);
  endtask : lvl

  task automatic pulse(input int n, input int k);
    repeat (k) begin
      lvl(n, 1'b1);
      lvl(n, 1'b0);
    end
  endtask : pulse

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    csrc = 8'h02;
    wsrc = 32'h0000_0000;
    ssrc = 32'h0000_0000;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc("ctrl0", `SMT_IDX_CTRL0, 32'h0000_0000);
    rdc("ctrl1", `SMT_IDX_CTRL1, 32'h0000_0000);
    rdc("status", `SMT_IDX_STAT, 32'h0000_0000);
    rdc("winsel", `SMT_IDX_WINSEL, 32'h0000_0000);
    chk("clk_req off", {31'h0, clk_req}, 32'h0000_0000);
    wr(`SMT_IDX_CTRL0, 32'h0000_00FF);
    rdc("ctrl0 rw", `SMT_IDX_CTRL0, 32'h0000_00BF);
    chk("clk_req on", {31'h0, clk_req}, 32'h0000_0001);
    wr(`SMT_IDX_CTRL1, 32'h0000_007F);
    rdc("ctrl1 rw", `SMT_IDX_CTRL1, 32'h0000_004F);
    wr(`SMT_IDX_CLKSEL, 32'h0000_00FF);
    rdc("clksel", `SMT_IDX_CLKSEL, 32'h0000_0007);
    wr(`SMT_IDX_SIGSEL, 32'h0000_00FF);
    rdc("sigsel", `SMT_IDX_SIGSEL, 32'h0000_001F);
    wr(`SMT_IDX_WINSEL, 32'h0000_00FF);
    rdc("winsel rw", `SMT_IDX_WINSEL, 32'h0000_001F);
    rdc("unmapped", 12'h480, 32'h0000_0000);
    chk("slverr", {31'h0, err}, 32'h0000_0001);
    for (m = 0; m < 16; m++) begin
      wr(`SMT_IDX_CTRL1, m);
      rdc("mode", `SMT_IDX_CTRL1, m);
    end
    // Plain timer from clock source 0, period 3, wrapping.
    wr(`SMT_IDX_CTRL0, 32'h0000_0000);
    wr(`SMT_IDX_CLKSEL, 32'h0000_0000);
    wr(`SMT_IDX_WINSEL, 32'h0000_0000);
    wr(`SMT_IDX_PERIOD, 32'h0000_0003);
    wr(`SMT_IDX_CTRL0, 32'h0000_0080);
    wr(`SMT_IDX_CTRL1, 32'h0000_0080);
    pulse(0, 5);
    rdc("wrap count", `SMT_IDX_COUNT, 32'h0000_0001);
    chk("match pulses", pm_cnt, 32'h0000_0001);
    rdc("running", `SMT_IDX_STAT, 32'h0000_0004);
    wr(`SMT_IDX_CTRL0, 32'h0000_00A0);
    pulse(0, 4);
    rdc("halt count", `SMT_IDX_COUNT, 32'h0000_0003);
    wr(`SMT_IDX_STAT, 32'h0000_0010);
    rdc("reset count", `SMT_IDX_COUNT, 32'h0000_0000);
    rdc("reset done", `SMT_IDX_STAT, 32'h0000_0004);
    // Divide by four, prescaler restarted by the disable.
    wr(`SMT_IDX_CTRL0, 32'h0000_0000);
    wr(`SMT_IDX_CTRL0, 32'h0000_0082);
    pulse(0, 8);
    rdc("prescale", `SMT_IDX_COUNT, 32'h0000_0002);
    // Falling edges of clock source 1, which idles high.
    wr(`SMT_IDX_CTRL0, 32'h0000_0000);
    wr(`SMT_IDX_CLKSEL, 32'h0000_0001);
    wr(`SMT_IDX_CTRL0, 32'h0000_0084);
    lvl(1, 1'b0);
    rdc("fall edge", `SMT_IDX_COUNT, 32'h0000_0001);
    lvl(1, 1'b1);
    rdc("rise edge", `SMT_IDX_COUNT, 32'h0000_0001);
    wr(`SMT_IDX_CTRL1, 32'h0000_0000);
    pulse(1, 2);
    rdc("go off", `SMT_IDX_COUNT, 32'h0000_0001);
    rdc("stopped", `SMT_IDX_STAT, 32'h0000_0000);
    wr(`SMT_IDX_CTRL1, 32'h0000_008B);
    pulse(1, 2);
    rdc("reserved", `SMT_IDX_COUNT, 32'h0000_0001);
    wr(`SMT_IDX_COUNT, 32'h0012_3456);
    wr(`SMT_IDX_STAT, 32'h0000_0080);
    rdc("pcap", `SMT_IDX_PCAP, 32'h0012_3456);
    wr(`SMT_IDX_STAT, 32'h0000_0040);
    rdc("wcap", `SMT_IDX_WCAP, 32'h0012_3456);
    rdc("req clear", `SMT_IDX_STAT, 32'h0000_0000);
    // Capture mode, repeating: one window rise and one fall.
    wr(`SMT_IDX_CTRL1, 32'h0000_00C7);
    wsrc[0] <= 1'b1;
    repeat (8) @(posedge clk);
    wsrc[0] <= 1'b0;
    repeat (8) @(posedge clk);
    chk("period acq", pa_cnt, 32'h0000_0001);
    chk("width acq", wa_cnt, 32'h0000_0001);
    rdc("pcap hw", `SMT_IDX_PCAP, 32'h0012_3456);
    wr(`SMT_IDX_CTRL1, 32'h0000_0000);
    wsrc[0] <= 1'b1;
    repeat (8) @(posedge clk);
    rdc("win high", `SMT_IDX_STAT, 32'h0000_0002);
    wr(`SMT_IDX_CTRL0, 32'h0000_0094);
    rdc("win inverted", `SMT_IDX_STAT, 32'h0000_0000);
    wr(`SMT_IDX_WINSEL, 32'h0000_0001);
    rdc("win source 1", `SMT_IDX_STAT, 32'h0000_0002);
    wr(`SMT_IDX_CTRL0, 32'h0000_0000);
    rdc("disabled", `SMT_IDX_COUNT, 32'h0000_0000);
    chk("clk_req dropped", {31'h0, clk_req}, 32'h0000_0000);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
